// [design/fse_pkg.sv]
// constants, types and register map of the fill and sleep executor
package fse_pkg;

  // ********************************
  // register map (byte offsets)
  // ********************************
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_BANK     = 8'h10;

  // ********************************
  // field positions
  // ********************************
  localparam int FLAG_TIMEOUT = 0;
  localparam int FLAG_PWRDN   = 1;
  localparam int FLAG_SLEEP   = 2;
  localparam int EV_FILL      = 0;
  localparam int EV_SLEEP     = 1;
  localparam int EV_WATCHDOG  = 2;
  localparam int CTRL_EXEC  = 0;
  localparam int EV_W       = 3;

  // ********************************
  // reset values
  // ********************************
  localparam logic            RST_TIMEOUT = 1'b1;
  localparam logic            RST_PWRDN   = 1'b1;
  localparam logic            RST_EXEC = 1'b1;
  localparam logic [EV_W-1:0] RST_MASK = 3'h0;
  localparam logic [3:0]      RST_BANK = 4'h0;

  // ********************************
  // instruction encodings
  // ********************************
  localparam logic [6:0]  OPC_FILL     = 7'h34;
  localparam logic [15:0] WORD_SLEEP   = 16'h0003;
  localparam logic [7:0]  FILL_VALUE   = 8'hFF;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_LOW   = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hF;

  // ********************************
  // instruction cycle phases
  // ********************************
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_WRITE  = 2'h3;
  localparam logic [1:0] PH_STEP   = 2'h1;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_ASLEEP = 2'h1,
    ST_WAKE   = 2'h3
  } pstate_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_wr_t;

endpackage

// [design/qphase_gen.sv]
// four-phase instruction cycle counter, halted while the core sleeps
`timescale 1ns/1ps
`default_nettype none
module qphase_gen
  import fse_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  output var  logic [1:0] phase
);

  logic [1:0] next_phase;

  // stopped oscillator: no phase advance while asleep
  always_comb begin
    next_phase = phase;
    if (run) begin
      next_phase = phase + PH_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= PH_DECODE;
    end else begin
      phase <= next_phase;
    end
  end

endmodule
`default_nettype wire

// [design/fill_and_sleep_exec.sv]
// executor for the fill-with-ones and sleep instructions, with apb registers
// ****************************************************************
// What this block does
// - fill targets the access bank when a is 0, else bank_select_reg.
// - sleep clears power_down_flag.
// - sleep sets timeout_flag.
// - sleep clears the watchdog counter and its postscaler.
// - sleep puts the core to sleep with the oscillator stopped.
// - a watchdog wake-up clears timeout_flag.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module fill_and_sleep_exec
  import fse_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire apb_req_t    APB_REQ,
  output var  apb_rsp_t    APB_RSP,
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR_WORD,
  input  wire logic        WAKE_WATCHDOG,
  input  wire logic        WAKE_OTHER,
  output var  mem_wr_t     MEM_WR,
  output var  logic        WATCHDOG_CLEAR,
  output var  logic        OSC_STOP,
  output var  logic        TIMEOUT_FLAG,
  output var  logic        POWER_DOWN_FLAG,
  output var  logic        IRQ
);

  // ********************************
  // state
  // ********************************
  pstate_t         state,      next_state;
  logic [1:0]      phase;
  logic [15:0]     instr,      next_instr;
  logic            instr_ok,   next_instr_ok;
  logic            timeout_flag,    next_timeout_flag;
  logic            power_down_flag, next_power_down_flag;
  logic [EV_W-1:0] irq_stat,   next_irq_stat;
  logic [EV_W-1:0] irq_mask,   next_irq_mask;
  logic            exec_en,    next_exec_en;
  logic [3:0]      bank_select_reg, next_bank_select_reg;
  mem_wr_t         next_mem_wr;
  logic            next_dog_clear, next_osc_stop, next_irq;
  apb_rsp_t        next_apb_rsp;
  logic            apb_wr, exec_fill, exec_sleep, wake_dog_ev;
  logic [EV_W-1:0] ev, w1c;
  logic [31:0]     rd_word;

  qphase_gen u_qphase (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .run   (state == ST_RUN),
    .phase (phase)
  );

  // ********************************
  // apb slave, one wait state
  // ********************************
  assign apb_wr = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready
                  & APB_REQ.pwrite;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (APB_REQ.paddr)
      OFS_FLAGS: begin
        rd_word[FLAG_TIMEOUT] = timeout_flag;
        rd_word[FLAG_PWRDN]   = power_down_flag;
        rd_word[FLAG_SLEEP]   = (state != ST_RUN);
      end
      OFS_IRQ_STAT: rd_word[EV_W-1:0] = irq_stat;
      OFS_IRQ_MASK: rd_word[EV_W-1:0] = irq_mask;
      OFS_CTRL:     rd_word[CTRL_EXEC] = exec_en;
      OFS_BANK:     rd_word[3:0] = bank_select_reg;
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_apb_rsp        = APB_RSP;
    next_apb_rsp.pready = APB_REQ.psel & APB_REQ.penable & ~APB_RSP.pready;
    next_apb_rsp.pslverr = 1'b0;
    if (APB_REQ.psel & APB_REQ.penable & ~APB_RSP.pready) begin
      next_apb_rsp.prdata = rd_word;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      APB_RSP <= '0;
    end else begin
      APB_RSP <= next_apb_rsp;
    end
  end

  // ********************************
  // instruction execution
  // ********************************
  assign exec_fill  = (state == ST_RUN) && (phase == PH_WRITE) && instr_ok
                      && (instr[15:9] == OPC_FILL);
  assign exec_sleep = (state == ST_RUN) && (phase == PH_WRITE) && instr_ok
                      && (instr == WORD_SLEEP);
  assign wake_dog_ev = (state == ST_ASLEEP) && WAKE_WATCHDOG;

  always_comb begin
    next_state           = state;
    next_instr           = instr;
    next_instr_ok        = instr_ok;
    next_timeout_flag    = timeout_flag;
    next_power_down_flag = power_down_flag;
    next_irq_mask        = irq_mask;
    next_exec_en         = exec_en;
    next_bank_select_reg = bank_select_reg;
    next_mem_wr          = '0;
    next_dog_clear       = 1'b0;
    next_osc_stop        = OSC_STOP;
    ev                   = '0;
    w1c                  = '0;
    if ((state == ST_RUN) && (phase == PH_DECODE)) begin
      next_instr    = INSTR_WORD;
      next_instr_ok = INSTR_VALID & exec_en;
    end
    if (exec_fill) begin
      next_mem_wr.we    = 1'b1;
      next_mem_wr.wdata = FILL_VALUE;
      if (!instr[8]) begin
        // access bank covers low and high ends of data memory
        next_mem_wr.addr = {(instr[7:0] < ACCESS_SPLIT) ? ACCESS_LOW
                            : ACCESS_HIGH, instr[7:0]};
      end else begin
        next_mem_wr.addr = {bank_select_reg, instr[7:0]};
      end
      ev[EV_FILL] = 1'b1;
    end
    case (state)
      ST_RUN: begin
        if (exec_sleep) begin
          next_power_down_flag = 1'b0;
          next_timeout_flag    = 1'b1;
          next_dog_clear       = 1'b1;
          next_osc_stop        = 1'b1;
          next_state           = ST_ASLEEP;
          ev[EV_SLEEP]         = 1'b1;
        end
      end
      ST_ASLEEP: begin
        if (WAKE_WATCHDOG | WAKE_OTHER) begin
          next_osc_stop = 1'b0;
          next_state    = ST_WAKE;
        end
        if (wake_dog_ev) begin
          next_timeout_flag = 1'b0;
          ev[EV_WATCHDOG]   = 1'b1;
        end
      end
      ST_WAKE: begin
        // restart from a fresh decode phase
        next_instr_ok = 1'b0;
        next_state    = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
    if (apb_wr) begin
      case (APB_REQ.paddr)
        OFS_IRQ_STAT: w1c = APB_REQ.pwdata[EV_W-1:0];
        OFS_IRQ_MASK: next_irq_mask = APB_REQ.pwdata[EV_W-1:0];
        OFS_CTRL:     next_exec_en = APB_REQ.pwdata[CTRL_EXEC];
        OFS_BANK:     next_bank_select_reg = APB_REQ.pwdata[3:0];
        default:      w1c = '0;
      endcase
    end
    // set beats clear in the same cycle
    next_irq_stat = (irq_stat & ~w1c) | ev;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state           <= ST_RUN;
      instr           <= 16'h0000;
      instr_ok        <= 1'b0;
      timeout_flag    <= RST_TIMEOUT;
      power_down_flag <= RST_PWRDN;
      irq_stat        <= '0;
      irq_mask        <= RST_MASK;
      exec_en         <= RST_EXEC;
      bank_select_reg <= RST_BANK;
      MEM_WR          <= '0;
      WATCHDOG_CLEAR  <= 1'b0;
      OSC_STOP        <= 1'b0;
      TIMEOUT_FLAG    <= RST_TIMEOUT;
      POWER_DOWN_FLAG <= RST_PWRDN;
      IRQ             <= 1'b0;
    end else begin
      state           <= next_state;
      instr           <= next_instr;
      instr_ok        <= next_instr_ok;
      timeout_flag    <= next_timeout_flag;
      power_down_flag <= next_power_down_flag;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      exec_en         <= next_exec_en;
      bank_select_reg <= next_bank_select_reg;
      MEM_WR          <= next_mem_wr;
      WATCHDOG_CLEAR  <= next_dog_clear;
      OSC_STOP        <= next_osc_stop;
      TIMEOUT_FLAG    <= next_timeout_flag;
      POWER_DOWN_FLAG <= next_power_down_flag;
      IRQ             <= next_irq;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_fill_go;
    exec_fill;
  endsequence
  sequence s_sleep_go;
    exec_sleep;
  endsequence
  // an early wake may drop osc_stop in the second cycle
  sequence s_sleep_done;
    WATCHDOG_CLEAR && OSC_STOP ##1 !WATCHDOG_CLEAR;
  endsequence

  a_fill_access_bank: assert property (
    s_fill_go and !instr[8] |=> MEM_WR.we && MEM_WR.addr[7:0] ==
      $past(instr[7:0]) && MEM_WR.addr[11:8] == (($past(instr[7:0])
      < ACCESS_SPLIT) ? ACCESS_LOW : ACCESS_HIGH))
    else $error("fill with a=0 missed the access bank");
  a_fill_bank_sel: assert property (
    s_fill_go and instr[8] |=>
      MEM_WR.addr == {$past(bank_select_reg), $past(instr[7:0])})
    else $error("fill with a=1 ignored bank_select_reg");
  a_sleep_pd_clear: assert property (
    s_sleep_go |=> !POWER_DOWN_FLAG && !power_down_flag)
    else $error("sleep left power_down_flag set");
  a_sleep_to_set: assert property (
    s_sleep_go |=> TIMEOUT_FLAG)
    else $error("sleep did not set timeout_flag");
  a_sleep_dog_clear: assert property (
    s_sleep_go |=> s_sleep_done)
    else $error("watchdog clear not a single pulse on sleep");
  a_sleep_osc_halt: assert property (
    s_sleep_go |=> state == ST_ASLEEP ##1 phase == $past(phase))
    else $error("core kept running after sleep");
  a_wake_to_clear: assert property (
    wake_dog_ev |=> !TIMEOUT_FLAG ##1 state == ST_RUN)
    else $error("watchdog wake kept timeout_flag");
  a_fill_value: assert property (
    s_fill_go |=> MEM_WR.we && MEM_WR.wdata == FILL_VALUE &&
      $stable(TIMEOUT_FLAG) && $stable(POWER_DOWN_FLAG) ##1 !MEM_WR.we)
    else $error("fill wrote wrong value or touched flags");

endmodule
`default_nettype wire

// [bench/fill_and_sleep_exec_bench.sv]
// self-checking bench of the fill and sleep executor
`timescale 1ns/1ps
`default_nettype none
module fill_and_sleep_exec_bench
  import fse_pkg::*;
();
  logic        clk;
  logic        rst;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic        ivalid;
  logic [15:0] iword;
  logic        wake_dog;
  logic        wake_oth;
  mem_wr_t     mwr;
  logic        dog_clr;
  logic        osc_stop;
  logic        tmo_flag;
  logic        pwr_flag;
  logic        irq;
  logic [31:0] rd;
  logic        rd_err;
  int          failures;
  int          n_compared;

  fill_and_sleep_exec i_dut (
    .CORE_CLK        (clk),
    .SYS_RST         (rst),
    .APB_REQ         (req),
    .APB_RSP         (rsp),
    .INSTR_VALID     (ivalid),
    .INSTR_WORD      (iword),
    .WAKE_WATCHDOG   (wake_dog),
    .WAKE_OTHER      (wake_oth),
    .MEM_WR          (mwr),
    .WATCHDOG_CLEAR  (dog_clr),
    .OSC_STOP        (osc_stop),
    .TIMEOUT_FLAG    (tmo_flag),
    .POWER_DOWN_FLAG (pwr_flag),
    .IRQ             (irq)
  );

  // ****************
  // shared tasks
  // ****************
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one request at a time; idle edge first so no signal is set twice
  task automatic apb(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= adr;
    req.pwdata  <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      failures++;
      $display("MISMATCH pready expected 1 seen %b", rsp.pready);
      stop_test();
    end
    rd = rsp.prdata;
    rd_err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr,
                        input logic [31:0] exp);
    apb(1'b0, adr, 32'h0000_0000);
    chk(what, exp, rd);
    chk("pslverr", 32'h0, {31'h0, rd_err});
  endtask

  // four edges of valid: exactly one falls on the decode phase
  task automatic exec(input logic [15:0] w);
    @(posedge clk);
    ivalid <= 1'b1;
    iword  <= w;
    repeat (4) @(posedge clk);
    ivalid <= 1'b0;
  endtask

  task automatic wait_evt(input logic clr);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((clr ? dog_clr : mwr.we) !== 1'b1 && n < 12);
    if ((clr ? dog_clr : mwr.we) !== 1'b1) begin
      failures++;
      $display("MISMATCH event expected 1 seen 0");
      stop_test();
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic reset_case();
    rd_chk("flags", OFS_FLAGS, 32'h0000_0003);
    rd_chk("ctrl", OFS_CTRL, 32'h0000_0001);
    rd_chk("mask", OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk("bank", OFS_BANK, 32'h0000_0000);
    apb(1'b1, OFS_FLAGS, 32'h0000_0000);
    rd_chk("flags ro", OFS_FLAGS, 32'h0000_0003);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
  endtask

  task automatic fill_case();
    logic [8:0]  op [4] = '{9'h05F, 9'h060, 9'h1FF, 9'h100};
    logic [11:0] ea [4] = '{12'h05F, 12'hF60, 12'hAFF, 12'hA00};
    apb(1'b1, OFS_BANK, 32'h0000_000A);
    rd_chk("bank", OFS_BANK, 32'h0000_000A);
    for (int i = 0; i < 4; i++) begin
      exec({OPC_FILL, op[i]});
      wait_evt(1'b0);
      chk("fill addr", {20'h0, ea[i]}, {20'h0, mwr.addr});
      chk("fill data", 32'h0000_00FF, {24'h0, mwr.wdata});
      chk("flags kept", 32'h3, {30'h0, pwr_flag, tmo_flag});
      tick();
      chk("fill pulse", 32'h0, {31'h0, mwr.we});
    end
    // execute enable off: instructions are dropped
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    exec({OPC_FILL, 9'h0_12});
    for (int i = 0; i < 8; i++) begin
      tick();
      chk("no fill off", 32'h0, {31'h0, mwr.we});
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
  endtask

  task automatic irq_case();
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    rd_chk("stat fill", OFS_IRQ_STAT, 32'h0000_0001);
    tick();
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) tick();
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
    rd_chk("stat clear", OFS_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
  endtask

  task automatic sleep_case(input logic by_dog);
    exec(WORD_SLEEP);
    wait_evt(1'b1);
    chk("osc stop", 32'h1, {31'h0, osc_stop});
    chk("timeout", 32'h1, {31'h0, tmo_flag});
    chk("pwr down", 32'h0, {31'h0, pwr_flag});
    tick();
    chk("dog pulse", 32'h0, {31'h0, dog_clr});
    rd_chk("asleep", OFS_FLAGS, 32'h0000_0005);
    exec({OPC_FILL, 9'h012});
    for (int i = 0; i < 8; i++) begin
      tick();
      chk("no fill asleep", 32'h0, {31'h0, mwr.we});
    end
    @(posedge clk);
    wake_dog <= by_dog;
    wake_oth <= !by_dog;
    @(posedge clk);
    wake_dog <= 1'b0;
    wake_oth <= 1'b0;
    tick();
    chk("osc run", 32'h0, {31'h0, osc_stop});
    chk("to wake", {31'h0, !by_dog}, {31'h0, tmo_flag});
    chk("pwr wake", 32'h0, {31'h0, pwr_flag});
  endtask

  // ****************
  // clock and main sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst        = 1'b1;
    req        = '0;
    ivalid     = 1'b0;
    iword      = 16'h0000;
    wake_dog   = 1'b0;
    wake_oth   = 1'b0;
    failures   = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_case();
    fill_case();
    irq_case();
    sleep_case(1'b0);
    sleep_case(1'b1);
    rd_chk("stat sleep", OFS_IRQ_STAT, 32'h0000_0006);
    chk("irq sleep", 32'h1, {31'h0, irq});
    // core runs again after wake; cleared flags must stay put
    exec({OPC_FILL, 9'h1_34});
    wait_evt(1'b0);
    chk("fill awake", 32'h0000_0A34, {20'h0, mwr.addr});
    chk("flags awake", 32'h0, {30'h0, pwr_flag, tmo_flag});
    stop_test();
  end
endmodule
`default_nettype wire
